// *** det_timer.sv ***
/*
  Two 8-bit timer/event counters with compare registers, square-wave
  outputs and a cascaded 16-bit interval mode, behind a plain register port.
  Assumes event pins are asynchronous and software drives a one-cycle
  strobe port; read data appear in the cycle after the read strobe.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Event mode counts chosen edge of event pin
// - Match clears counter, pulses its request
// - Compare any 00h..ffh, counts zero to compare
// - Enabled wave output inverts on every match without a same-cycle level write
// - Wave half period is compare plus one
// - Level set/clear bits preset wave A
// - Select bits 4..7 pick counter B clock
// - Select bits 0..3 pick counter A clock
// - Mode bit 2 chains both counters
// - Chained: A uses own clock, B on carry
// - Chained: mode bit 0 runs or stops
// - Chained full match clears both, pulses B
// - Chained A match still pulses A, toggles A
// - Divide select halves every tap period
module det_timer #(
  parameter int TAP_MAX = det_pkg::TAP_MAX
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Register port
  input  wire logic [det_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [det_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [det_pkg::DATA_W-1:0]  regRdData,
  // Event input pins
  input  wire logic                        eventInA,
  input  wire logic                        eventInB,
  // Square-wave output pins
  output logic                             waveOutA,
  output logic                             waveOutB,
  // Match requests to the interrupt controller
  output logic                             matchIrqA,
  output logic                             matchIrqB
);

  // Elaboration check: tap codes need exponents up to the top slow tap
  if (TAP_MAX < int'(det_pkg::TAP_TOP_SLOW) || TAP_MAX > 15) begin : gBadTap
    $error("det_timer: TAP_MAX cannot serve the clock select codes");
  end

  // Software registers
  logic [7:0]                 clockSelect_r;
  logic [det_pkg::MODE_W-1:0] modeControl_r;
  logic                       waveAEnable_r;
  logic                       waveBEnable_r;
  logic                       oscDivideSelect_r;
  logic [7:0]                 compareA_r;
  logic [7:0]                 compareB_r;

  // Counters and outputs
  logic [7:0]                 countA_r;
  logic [7:0]                 countB_r;
  logic                       waveA_r;
  logic                       waveB_r;
  logic                       irqA_r;
  logic                       irqB_r;
  logic [det_pkg::DATA_W-1:0] rdData_r;

  // Decoded controls
  logic                       cascade;
  logic                       runA;
  logic                       runB;
  logic [TAP_MAX:0]           tap;
  logic [1:0]                 evRise;
  logic [1:0]                 evFall;
  logic [1:0]                 tick;
  logic                       tickA;
  logic                       tickB;
  logic                       eqA;
  logic                       eqB;
  logic                       fullMatch;
  logic                       matchA;
  logic                       matchB;
  logic                       levelSetWr;
  logic                       levelClrWr;
  logic                       writeOutCtl;

  // Map a select code to a tap exponent, zero means no clock
  function automatic logic [3:0] tapExp(input logic [3:0] sel,
                                        input logic       fast);
    logic [3:0] e;
    e = 4'h0;
    if (sel >= det_pkg::SEL_TAP_FIRST && sel < det_pkg::SEL_TAP_LAST) begin
      e = fast ? sel - det_pkg::TAP_OFS_FAST : sel - det_pkg::TAP_OFS_SLOW;
    end else if (sel == det_pkg::SEL_TAP_LAST) begin
      e = fast ? det_pkg::TAP_TOP_FAST : det_pkg::TAP_TOP_SLOW;
    end
    return e;
  endfunction : tapExp

  // Prescaler taps, halved periods when divide select is set
  det_prescaler #(
    .TAP_MAX (TAP_MAX)
  ) uPrescaler (
    .clk     (clk),
    .rst_n   (rst_n),
    .tap     (tap)
  );

  // Per-channel event synchroniser, edge finder and clock selection
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    logic       pin;
    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic [3:0] sel;
    logic [3:0] exp;

    assign pin = (ch == 0) ? eventInA : eventInB;
    assign sel = clockSelect_r[ch*det_pkg::SEL_W +: det_pkg::SEL_W];

    // Two-stage synchroniser, then a history stage
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
        prev_r  <= 1'b0;
      end else begin
        sync1_r <= pin;
        sync2_r <= sync1_r;
        prev_r  <= sync2_r;
      end
    end

    // Edges seen only on the synchronised level
    assign evRise[ch] = sync2_r & ~prev_r;
    assign evFall[ch] = ~sync2_r & prev_r;

    assign exp = tapExp(sel, oscDivideSelect_r);

    // Count clock choice; unlisted codes give no clock
    always_comb begin
      case (sel)
        det_pkg::SEL_EVT_FALL: tick[ch] = evFall[ch];
        det_pkg::SEL_EVT_RISE: tick[ch] = evRise[ch];
        default:               tick[ch] = tap[exp];
      endcase
    end
  end

  // Channel clocks: A from bits 0..3, B from bits 4..7
  assign tickA = tick[0];
  assign tickB = tick[1];

  // Mode decode
  assign cascade = modeControl_r[det_pkg::MODE_CASCADE_BIT];
  assign runA    = modeControl_r[det_pkg::MODE_RUN_BIT];
  assign runB    = cascade ? modeControl_r[det_pkg::MODE_RUN_BIT]
                           : modeControl_r[det_pkg::MODE_RUN_B_BIT];

  // Compare decode
  assign eqA       = (countA_r == compareA_r);
  assign eqB       = (countB_r == compareB_r);
  assign fullMatch = eqA & eqB;

  // Match events of each channel
  assign matchA = runA & tickA & eqA;
  assign matchB = cascade ? (runA & tickA & fullMatch)
                          : (runB & tickB & eqB);

  // Output control write actions
  assign writeOutCtl = regWr && (regAddr == det_pkg::OFF_OUTCTL);
  assign levelSetWr  = writeOutCtl & regWrData[det_pkg::OUT_LVL_SET_BIT];
  assign levelClrWr  = writeOutCtl & regWrData[det_pkg::OUT_LVL_CLR_BIT];

  // Clock select register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clockSelect_r <= det_pkg::CLKSEL_RST;
    end else if (regWr && regAddr == det_pkg::OFF_CLKSEL) begin
      clockSelect_r <= regWrData[7:0];
    end
  end

  // Mode control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeControl_r <= det_pkg::MODE_RST;
    end else if (regWr && regAddr == det_pkg::OFF_MODE) begin
      modeControl_r <= regWrData[det_pkg::MODE_W-1:0];
    end
  end

  // Output enables
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waveAEnable_r <= 1'b0;
      waveBEnable_r <= 1'b0;
    end else if (writeOutCtl) begin
      waveAEnable_r <= regWrData[det_pkg::OUT_EN_A_BIT];
      waveBEnable_r <= regWrData[det_pkg::OUT_EN_B_BIT];
    end
  end

  // Oscillation mode register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscDivideSelect_r <= 1'b0;
    end else if (regWr && regAddr == det_pkg::OFF_OSC) begin
      oscDivideSelect_r <= regWrData[det_pkg::OSC_DIV_BIT];
    end
  end

  // Compare registers, full 8-bit range accepted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compareA_r <= det_pkg::CMP_RST;
      compareB_r <= det_pkg::CMP_RST;
    end else if (regWr) begin
      if (regAddr == det_pkg::OFF_CMP_A) begin
        compareA_r <= regWrData[7:0];
      end
      if (regAddr == det_pkg::OFF_CMP_B) begin
        compareB_r <= regWrData[7:0];
      end
    end
  end

  // Counter A: clears on its own match, or only on full match when chained
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countA_r <= det_pkg::COUNT_RST;
    end else if (!runA) begin
      countA_r <= det_pkg::COUNT_RST;
    end else if (tickA) begin
      if (cascade) begin
        if (fullMatch) begin
          countA_r <= det_pkg::COUNT_RST;
        end else begin
          countA_r <= countA_r + 8'h01;
        end
      end else if (eqA) begin
        countA_r <= det_pkg::COUNT_RST;
      end else begin
        countA_r <= countA_r + 8'h01;
      end
    end
  end

  // Counter B: own clock, or the carry out of counter A when chained
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countB_r <= det_pkg::COUNT_RST;
    end else if (!runB) begin
      countB_r <= det_pkg::COUNT_RST;
    end else if (cascade) begin
      if (tickA) begin
        if (fullMatch) begin
          countB_r <= det_pkg::COUNT_RST;
        end else if (countA_r == det_pkg::COUNT_TOP) begin
          countB_r <= countB_r + 8'h01;
        end
      end
    end else if (tickB) begin
      if (eqB) begin
        countB_r <= det_pkg::COUNT_RST;
      end else begin
        countB_r <= countB_r + 8'h01;
      end
    end
  end

  // Request pulses, one cycle per match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqA_r <= 1'b0;
      irqB_r <= 1'b0;
    end else begin
      irqA_r <= matchA;
      irqB_r <= matchB;
    end
  end

  // Wave A: software level preset wins over a match toggle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waveA_r <= 1'b0;
    end else if (levelSetWr && !levelClrWr) begin
      waveA_r <= 1'b1;
    end else if (levelClrWr && !levelSetWr) begin
      waveA_r <= 1'b0;
    end else if (matchA && waveAEnable_r) begin
      waveA_r <= ~waveA_r;
    end
  end

  // Wave B toggles on its match, full match when chained
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waveB_r <= 1'b0;
    end else if (matchB && waveBEnable_r) begin
      waveB_r <= ~waveB_r;
    end
  end

  // Read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r <= '0;
    end else if (regRd) begin
      case (regAddr)
        det_pkg::OFF_CLKSEL: rdData_r <= {8'h00, clockSelect_r};
        det_pkg::OFF_MODE:   rdData_r <= {13'h0000, modeControl_r};
        det_pkg::OFF_OUTCTL: rdData_r <= {11'h000, waveBEnable_r, 3'h0,
                                          waveAEnable_r};
        det_pkg::OFF_OSC:    rdData_r <= {15'h0000, oscDivideSelect_r};
        det_pkg::OFF_CMP_A:  rdData_r <= {8'h00, compareA_r};
        det_pkg::OFF_CMP_B:  rdData_r <= {8'h00, compareB_r};
        det_pkg::OFF_COUNT:  rdData_r <= {countB_r, countA_r};
        default:             rdData_r <= '0;
      endcase
    end else begin
      rdData_r <= '0;
    end
  end

  // Output drive
  assign regRdData = rdData_r;
  assign waveOutA  = waveA_r;
  assign waveOutB  = waveB_r;
  assign matchIrqA = irqA_r;
  assign matchIrqB = irqB_r;

endmodule : det_timer

`default_nettype wire

// *** det_pkg.sv ***
/*
  Shared constants of the dual 8-bit event timer: register offsets,
  field positions, clock select codes, reset values and timing figures.
  Assumes a 100 MHz system clock that also serves as the prescaler input.
*/
`default_nettype none

package det_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CLKSEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MODE   = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_OUTCTL = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_OSC    = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CMP_A  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CMP_B  = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 4'h6;

  // Clock select fields
  localparam int SEL_W       = 4;
  localparam int SEL_A_LSB   = 0;
  localparam int SEL_B_LSB   = 4;

  // Mode control fields
  localparam int MODE_RUN_BIT     = 0;
  localparam int MODE_RUN_B_BIT   = 1;
  localparam int MODE_CASCADE_BIT = 2;
  localparam int MODE_W           = 3;

  // Output control fields
  localparam int OUT_EN_A_BIT    = 0;
  localparam int OUT_LVL_SET_BIT = 2;
  localparam int OUT_LVL_CLR_BIT = 3;
  localparam int OUT_EN_B_BIT    = 4;

  // Oscillation mode field
  localparam int OSC_DIV_BIT = 0;

  // Clock select codes
  localparam logic [SEL_W-1:0] SEL_EVT_FALL  = 4'h0;
  localparam logic [SEL_W-1:0] SEL_EVT_RISE  = 4'h1;
  localparam logic [SEL_W-1:0] SEL_TAP_FIRST = 4'h6;
  localparam logic [SEL_W-1:0] SEL_TAP_LAST  = 4'hf;

  // Tap exponents: period is 2**exp system clocks
  localparam int            TAP_MAX      = 12;
  localparam logic [3:0]    TAP_OFS_FAST = 4'h5;
  localparam logic [3:0]    TAP_OFS_SLOW = 4'h4;
  localparam logic [3:0]    TAP_TOP_FAST = 4'hb;
  localparam logic [3:0]    TAP_TOP_SLOW = 4'hc;

  // Reset values
  localparam logic [7:0]        CLKSEL_RST = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST   = 3'h0;
  localparam logic [7:0]        CMP_RST    = 8'h00;
  localparam logic [7:0]        COUNT_RST  = 8'h00;
  localparam logic [7:0]        COUNT_TOP  = 8'hff;

  // Event input synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage : det_pkg

`default_nettype wire

// *** det_prescaler.sv ***
/*
  Free-running prescaler for the event timer: one-cycle enable pulses
  with periods of 2**e system clocks, e = 1 .. TAP_MAX.
  Assumes the single system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module det_prescaler #(
  parameter int TAP_MAX = det_pkg::TAP_MAX
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Tap pulses, bit 0 never fires
  output logic      [TAP_MAX:0]   tap
);

  // Elaboration check on tap range
  if (TAP_MAX < 1 || TAP_MAX > 16) begin : gBadTap
    $error("det_prescaler: TAP_MAX out of range");
  end

  logic [TAP_MAX-1:0] div_r;

  // Free-running divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tap[0] = 1'b0;

  // One pulse per 2**e cycles on each tap
  for (genvar e = 1; e <= TAP_MAX; e++) begin : gTap
    assign tap[e] = &div_r[e-1:0];
  end

endmodule : det_prescaler

`default_nettype wire

// *** det_timer_monitor.sv ***
/*
  Port checker for det_timer: register read-back, request pulses,
  wave causes and stop behaviour.
  Assumes binding to det_timer, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module det_timer_monitor (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [det_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [det_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  input  wire logic [det_pkg::DATA_W-1:0] regRdData,
  // Outputs
  input  wire logic                       waveOutA,
  input  wire logic                       waveOutB,
  input  wire logic                       matchIrqA,
  input  wire logic                       matchIrqB
);
  logic [7:0] selCopy_r;
  logic [2:0] modeCopy_r;

  // Shadow copies of clock select and mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selCopy_r  <= 8'h00;
      modeCopy_r <= 3'h0;
    end else if (regWr && regAddr == det_pkg::OFF_CLKSEL) begin
      selCopy_r <= regWrData[7:0];
    end else if (regWr && regAddr == det_pkg::OFF_MODE) begin
      modeCopy_r <= regWrData[2:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sReadOf(logic [3:0] a);
    regRd && regAddr == a;
  endsequence
  sequence sStopped;
    modeCopy_r[1:0] == 2'b00 && $past(modeCopy_r[1:0]) == 2'b00;
  endsequence

  a_sel_read: assert property (sReadOf(det_pkg::OFF_CLKSEL) |=>
    regRdData == {8'h00, $past(selCopy_r)}) else $error("clock select read-back wrong");
  a_osc_read: assert property (sReadOf(det_pkg::OFF_OSC) |=>
    regRdData[15:1] == 15'h0000) else $error("osc mode read has extra bits");
  a_irqa_one_cycle: assert property (matchIrqA |=> !matchIrqA)
    else $error("request A longer than one cycle");
  a_irqb_one_cycle: assert property (matchIrqB |=> !matchIrqB)
    else $error("request B longer than one cycle");
  a_wave_a_cause: assert property ($changed(waveOutA) |-> matchIrqA ||
    $past(regWr && regAddr == det_pkg::OFF_OUTCTL)) else $error("wave A moved alone");
  a_wave_b_cause: assert property ($changed(waveOutB) |-> matchIrqB)
    else $error("wave B moved without match");
  a_stop_quiet: assert property (sStopped |-> !matchIrqA && !matchIrqB)
    else $error("request while stopped");
  a_chain_both: assert property (modeCopy_r[2] && $past(modeCopy_r[2]) && matchIrqB
    |-> matchIrqA) else $error("chained full match missed request A");
  a_count_stop: assert property (sStopped ##0 sReadOf(det_pkg::OFF_COUNT) |=>
    regRdData == 16'h0000) else $error("stopped count not zero");
endmodule : det_timer_monitor

bind det_timer det_timer_monitor det_timer_monitor_inst (.clk, .rst_n, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .waveOutA, .waveOutB, .matchIrqA, .matchIrqB);

`default_nettype wire

// *** det_pulse_src.sv ***
/*
  External pulse source feeding the two event pins.
  Assumes the bench calls burst; pins idle low between bursts.
*/
`timescale 1ns/1ps
`default_nettype none

module det_pulse_src (
  // Clock
  input  wire logic clk,
  // Event pins
  output var logic  pinA,
  output var logic  pinB
);
  // Idle low from time zero
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end

  // Pulse train, each level held width clocks
  task automatic burst(input bit chB, input int n, input int width);
    for (int i = 0; i < n; i++) begin
      repeat (width) @(posedge clk);
      if (chB) pinB <= 1'b1;
      else pinA <= 1'b1;
      repeat (width) @(posedge clk);
      if (chB) pinB <= 1'b0;
      else pinA <= 1'b0;
    end
  endtask : burst
endmodule : det_pulse_src

`default_nettype wire

// *** tb_top.sv ***
/*
  Self-checking bench for det_timer with a pulse source on the event pins.
  Assumes a 100 MHz clock and the register map of det_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk, rst_n, regWr, regRd, waveOutA, waveOutB, matchIrqA, matchIrqB;
  logic        eventInA, eventInB;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, regRdData, d;
  int          n_fail, compares, cyc, g, na, nb;

  // Clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  det_timer det_timer_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .eventInA(eventInA), .eventInB(eventInB), .waveOutA(waveOutA), .waveOutB(waveOutB),
    .matchIrqA(matchIrqA), .matchIrqB(matchIrqB));
  det_pulse_src det_pulse_src_inst (.clk(clk), .pinA(eventInA), .pinB(eventInB));

  task automatic close_out();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkn(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask : rd

  // Count request pulses over n cycles
  task automatic pulses(input int n, output int a, output int b);
    a = 0;
    b = 0;
    repeat (n) begin
      @(posedge clk);
      #1 a += (matchIrqA !== 1'b0);
      b += (matchIrqB !== 1'b0);
    end
  endtask : pulses

  // Cycles between two requests of one channel, plus A requests between
  task automatic gapOf(input bit chB, output int gap, output int aCnt);
    int k;
    gap = 0;
    aCnt = 0;
    k = 0;
    while (k < 6000 && (chB ? matchIrqB : matchIrqA) !== 1'b1) begin
      @(posedge clk);
      #1 k++;
    end
    do begin
      @(posedge clk);
      #1 gap++;
      aCnt += (matchIrqA !== 1'b0);
    end while (gap < 6000 && (chB ? matchIrqB : matchIrqA) !== 1'b1);
  endtask : gapOf

  task automatic t_regs();
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk(d, 16'h0000);
    end
    wr(det_pkg::OFF_CLKSEL, 16'h1234);
    rd(det_pkg::OFF_CLKSEL, d);
    chk(d, 16'h0034);
    wr(det_pkg::OFF_OSC, 16'hffff);
    rd(det_pkg::OFF_OSC, d);
    chk(d, 16'h0001);
  endtask : t_regs

  task automatic t_events();
    wr(det_pkg::OFF_CLKSEL, 16'h0001);
    wr(det_pkg::OFF_CMP_A, 16'h00ff);
    wr(det_pkg::OFF_CMP_B, 16'h00ff);
    wr(det_pkg::OFF_MODE, 16'h0003);
    fork
      det_pulse_src_inst.burst(1'b0, 5, 2);
      det_pulse_src_inst.burst(1'b1, 3, 3);
    join
    repeat (5) @(posedge clk);
    rd(det_pkg::OFF_COUNT, d);
    chk(d, 16'h0305);
    wr(det_pkg::OFF_MODE, 16'h0000);
  endtask : t_events

  task automatic t_square(input bit chB, input bit dv, input int code, input int cmp);
    logic w1;
    wr(det_pkg::OFF_OSC, {15'h0000, dv});
    wr(det_pkg::OFF_CLKSEL, 16'(code << (chB ? 4 : 0)));
    wr(chB ? det_pkg::OFF_CMP_B : det_pkg::OFF_CMP_A, 16'(cmp));
    wr(det_pkg::OFF_OUTCTL, chB ? 16'h0010 : 16'h0001);
    wr(det_pkg::OFF_MODE, chB ? 16'h0002 : 16'h0001);
    gapOf(chB, g, na);
    w1 = chB ? waveOutB : waveOutA;
    gapOf(chB, g, na);
    chkn(g, (cmp + 1) * (1 << (code - (dv ? 5 : 4) + (code == 15 ? 1 : 0))));
    chk({15'h0000, chB ? waveOutB : waveOutA}, {15'h0000, ~w1});
    wr(det_pkg::OFF_MODE, 16'h0000);
  endtask : t_square

  task automatic t_level();
    wr(det_pkg::OFF_OUTCTL, 16'h0008);
    #1 chk({15'h0000, waveOutA}, 16'h0000);
    wr(det_pkg::OFF_OUTCTL, 16'h0004);
    #1 chk({15'h0000, waveOutA}, 16'h0001);
    wr(det_pkg::OFF_OUTCTL, 16'h0008);
    #1 chk({15'h0000, waveOutA}, 16'h0000);
  endtask : t_level

  task automatic t_cascade();
    wr(det_pkg::OFF_OSC, 16'h0001);
    wr(det_pkg::OFF_CLKSEL, 16'h00f6);
    wr(det_pkg::OFF_CMP_A, 16'h0002); // low byte
    wr(det_pkg::OFF_CMP_B, 16'h0001); // high byte
    wr(det_pkg::OFF_MODE, 16'h0005); // run and chained; A requests still pulse
    gapOf(1'b1, g, na);
    gapOf(1'b1, g, na);
    chkn(g, (16'h0102 + 1) * 2);
    chkn(na, 2);
    // 256 ticks after the full match: carry from A into B, read as one word
    repeat (511) @(posedge clk);
    rd(det_pkg::OFF_COUNT, d);
    chk(d, 16'h0100);
    wr(det_pkg::OFF_MODE, 16'h0004);
    pulses(600, na, nb);
    chkn(nb, 0);
    rd(det_pkg::OFF_COUNT, d); // single wide read
    chk(d, 16'h0000);
  endtask : t_cascade

  task automatic t_unlisted();
    wr(det_pkg::OFF_CLKSEL, 16'h0002);
    wr(det_pkg::OFF_CMP_A, 16'h0000);
    wr(det_pkg::OFF_MODE, 16'h0001);
    pulses(200, na, nb);
    chkn(na, 0);
    rd(det_pkg::OFF_COUNT, d);
    chk(d, 16'h0000);
    wr(det_pkg::OFF_MODE, 16'h0000);
  endtask : t_unlisted

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = 4'h0;
    regWrData = 16'h0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_square(1'b0, 1'b1, 6, 0);
    t_square(1'b0, 1'b0, 6, 2);
    t_square(1'b0, 1'b1, 15, 0);
    t_square(1'b1, 1'b1, 7, 5);
    t_square(1'b1, 1'b1, 14, 1);
    t_level();
    t_cascade();
    t_unlisted();
    close_out();
  end
endmodule : tb_top

`default_nettype wire
